// ### crc_pkg.sv
package crc_pkg;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 4;
	localparam int RTC_PERIOD_NS   = 30518;
	localparam int RTC_DIV_CYC     = (RTC_PERIOD_NS + CLK_PERIOD_NS - 1)
	                                 / CLK_PERIOD_NS;
	localparam int MIN_BUS_RATIO   = 7;
	localparam int BKP_WORDS       = 20;
	localparam logic [1:0] ALARM_ARM_TICKS = 2'h3;
	localparam logic [2:0] INIT_EXIT_TICKS = 3'h4;

	// -------------------------------------------------------------
	// register offsets (byte addresses)
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_TIME   = 8'h00;
	localparam logic [7:0] OFF_DATE   = 8'h04;
	localparam logic [7:0] OFF_CTL    = 8'h08;
	localparam logic [7:0] OFF_ICS    = 8'h0C;
	localparam logic [7:0] OFF_PSC    = 8'h10;
	localparam logic [7:0] OFF_WUT    = 8'h14;
	localparam logic [7:0] OFF_SS     = 8'h18;
	localparam logic [7:0] OFF_AL0TD  = 8'h1C;
	localparam logic [7:0] OFF_AL1TD  = 8'h20;
	localparam logic [7:0] OFF_AL0SS  = 8'h24;
	localparam logic [7:0] OFF_AL1SS  = 8'h28;
	localparam logic [7:0] OFF_WPK    = 8'h2C;
	localparam logic [7:0] OFF_BKP    = 8'h50;

	// -------------------------------------------------------------
	// masks, reset values, keys
	// -------------------------------------------------------------
	localparam logic [31:0] TIME_MASK = 32'h007F_7F7F;
	localparam logic [31:0] DATE_MASK = 32'h00FF_FF3F;
	localparam logic [31:0] CTL_MASK  = 32'h0007_4777;
	localparam logic [31:0] CTL_PROT  = 32'h0003_0050;
	localparam logic [31:0] PSC_MASK  = 32'h007F_7FFF;
	localparam logic [31:0] ALTD_MASK = 32'hBFBF_FFFF;
	localparam logic [31:0] ALSS_MASK = 32'h0100_7FFF;
	localparam logic [31:0] PSC_RST   = 32'h007F_00FF;
	localparam logic [31:0] DATE_RST  = 32'h0000_2101;
	localparam logic [7:0]  KEY_FIRST = 8'hCA;
	localparam logic [7:0]  KEY_SECOND = 8'h53;
	localparam int WT_SEC_SEL  = 2;
	localparam int WT_LONG_SEL = 1;

	// -------------------------------------------------------------
	// bcd limits
	// -------------------------------------------------------------
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE  = 8'h01;
	localparam logic [7:0] SEC_MAX  = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] WDAY_MAX = 8'h07;
	localparam logic [7:0] MON_MAX  = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] DAY_FEB  = 8'h28;
	localparam logic [7:0] DAY_LEAP = 8'h29;
	localparam logic [7:0] DAY_30   = 8'h30;
	localparam logic [7:0] DAY_31   = 8'h31;

	// -------------------------------------------------------------
	// register layouts
	// -------------------------------------------------------------
	typedef struct packed {
		logic [8:0] rsv; logic pm; logic [5:0] hour;
		logic rsv1; logic [6:0] min; logic rsv2; logic [6:0] sec;
	} crc_time_t;
	typedef struct packed {
		logic [7:0] rsv; logic [7:0] year; logic [2:0] weekday;
		logic [4:0] month; logic [1:0] rsv1; logic [5:0] day;
	} crc_date_t;
	typedef struct packed {
		logic [12:0] rsv; logic daylight_record_bit; logic subHour; logic addHour;
		logic rsv1; logic wakeIrqEn; logic [2:0] rsv2; logic wakeEn;
		logic [1:0] alarmEn; logic rsv3; logic fmt12; logic bypass;
		logic refclock_detect_enable; logic rsv4; logic [2:0] wakeup_clock_select;
	} crc_ctl_t;
	typedef struct packed {
		logic [22:0] rsv; logic keyPrivOnly; logic initReq;
		logic initFlag; logic syncFlag; logic [1:0] rsv1;
		logic wakeFlag; logic [1:0] alarmFlag;
	} crc_ics_t;
	typedef struct packed {
		logic [8:0] rsv; logic [6:0] async; logic rsv1; logic [14:0] sync;
	} crc_psc_t;
	typedef struct packed {
		logic mDay; logic rsv; logic [5:0] day;
		logic mHour; logic rsv1; logic [5:0] hour;
		logic mMin; logic [6:0] min; logic mSec; logic [6:0] sec;
	} crc_alrm_t;
	typedef struct packed {
		logic [6:0] rsv; logic mSub; logic [8:0] rsv1; logic [14:0] ss;
	} crc_alss_t;

	typedef enum logic [2:0] {
		KEY_LOCKED = 3'b001,
		KEY_HALF   = 3'b010,
		KEY_OPEN   = 3'b100
	} crc_key_t;

endpackage : crc_pkg

// ### crc_calendar_rtc_core.sv
module crc_calendar_rtc_core
	import crc_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_CYC,
	parameter int BKP_NUM = BKP_WORDS
) (
	input  logic        clk,
	input  logic        rst_b,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	input  logic [2:0]  pprot,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic        lowPowerMode,
	input  logic        sysResetReq,
	input  logic        tamperDetect,
	input  logic        backupWriteEnable,
	output logic        wakeupIrq
);

	// -------------------------------------------------------------
	// parameter checks
	// -------------------------------------------------------------
	if (RTC_DIV < MIN_BUS_RATIO || RTC_DIV > 65535) begin : bad_div
		$error("rtc divider out of range");
	end
	if (BKP_NUM < 1 || BKP_NUM > 44) begin : bad_bkp
		$error("backup word count out of range");
	end

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [15:0] divCnt_q,   divCnt_d;
	logic        rtcPhase_q, rtcPhase_d;
	logic [6:0]  asyncCnt_q, asyncCnt_d;
	logic [14:0] ss_q,       ss_d;
	logic [14:0] shSs_q,     shSs_d;
	crc_time_t   liveTime_q, liveTime_d;
	crc_time_t   shTime_q,   shTime_d;
	crc_date_t   liveDate_q, liveDate_d;
	crc_date_t   shDate_q,   shDate_d;
	crc_ctl_t    ctl_q,      ctl_d;
	crc_ics_t    ics_q,      ics_d;
	crc_psc_t    psc_q,      psc_d;
	logic [15:0] wut_q,      wut_d;
	logic [16:0] wuCnt_q,    wuCnt_d;
	logic [3:0]  wuDiv_q,    wuDiv_d;
	crc_alrm_t   alTd_q [2];
	crc_alrm_t   alTd_d [2];
	crc_alss_t   alSs_q [2];
	crc_alss_t   alSs_d [2];
	logic [1:0]  alArm_q [2];
	logic [1:0]  alArm_d [2];
	logic [1:0]  alPrev_q,   alPrev_d;
	logic [2:0]  exitCnt_q,  exitCnt_d;
	crc_key_t    key_q,      key_d;
	logic [31:0] bkp_q [BKP_NUM];
	logic [31:0] bkp_d [BKP_NUM];
	logic [31:0] prdata_q,   prdata_d;
	logic        pready_q,   pready_d;
	logic        pslverr_q,  pslverr_d;
	logic        wakeIrq_q,  wakeIrq_d;

	logic        rtcTick;
	logic        asyncTick;
	logic        secondTick;
	logic        wuTick;
	logic        running;
	logic        shadowCopy;
	logic        loadLive;
	logic        setup;
	logic        wr;
	logic        unlocked;
	logic        keyOk;
	logic        bkpHit;
	logic        rdErr;
	logic        wakeSet;
	logic [4:0]  bkpIdx;
	logic [7:0]  bkpOff;
	logic [7:0]  lastDayNow;
	logic [3:0]  wuMask;
	logic [16:0] wuReload;
	logic [31:0] rdat;
	logic [1:0]  alHit;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic logic [7:0] bcdInc(input logic [7:0] v,
		input logic [7:0] maxV, input logic [7:0] minV);
		if (v == maxV) begin
			bcdInc = minV;
		end else if (v[3:0] == 4'h9) begin
			bcdInc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcdInc = v + 8'h01;
		end
	endfunction : bcdInc

	function automatic logic [7:0] bcdDec(input logic [7:0] v);
		if (v[3:0] == 4'h0) begin
			bcdDec = {v[7:4] - 4'h1, 4'h9};
		end else begin
			bcdDec = v - 8'h01;
		end
	endfunction : bcdDec

	// last day of the month in bcd, with leap years
	function automatic logic [7:0] lastDay(input logic [4:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
		            : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			5'h02:                      lastDay = leap ? DAY_LEAP : DAY_FEB;
			5'h04, 5'h06, 5'h09, 5'h11: lastDay = DAY_30;
			default:                    lastDay = DAY_31;
		endcase
	endfunction : lastDay

	// masked fields always count as matching
	function automatic logic alarmMatch(input crc_alrm_t a,
		input crc_alss_t s, input crc_time_t t, input crc_date_t d,
		input logic [14:0] ss);
		alarmMatch = (a.mSec  || a.sec  == t.sec)  &&
		             (a.mMin  || a.min  == t.min)  &&
		             (a.mHour || a.hour == t.hour) &&
		             (a.mDay  || a.day  == d.day)  &&
		             (s.mSub  || s.ss   == ss);
	endfunction : alarmMatch

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	always_comb begin
		divCnt_d = divCnt_q;   rtcPhase_d = rtcPhase_q;
		asyncCnt_d = asyncCnt_q; ss_d = ss_q; shSs_d = shSs_q;
		liveTime_d = liveTime_q; shTime_d = shTime_q;
		liveDate_d = liveDate_q; shDate_d = shDate_q;
		ctl_d = ctl_q; ics_d = ics_q; psc_d = psc_q; wut_d = wut_q;
		wuCnt_d = wuCnt_q; wuDiv_d = wuDiv_q; alTd_d = alTd_q;
		alSs_d = alSs_q; alArm_d = alArm_q; exitCnt_d = exitCnt_q;
		key_d = key_q; bkp_d = bkp_q; wakeSet = 1'b0;

		// rtc clock as an enable pulse from the system clock
		rtcTick = (divCnt_q == 16'(RTC_DIV - 1));
		divCnt_d = rtcTick ? 16'h0000 : divCnt_q + 16'h0001;
		if (rtcTick) begin
			rtcPhase_d = ~rtcPhase_q;
		end

		// init handshake: the flag follows the request on an rtc tick
		running = !ics_q.initFlag && (exitCnt_q == 3'h0);
		loadLive = rtcTick && (exitCnt_q == 3'h1);
		if (rtcTick) begin
			if (ics_q.initReq && !ics_q.initFlag) begin
				ics_d.initFlag = 1'b1;
			end else if (!ics_q.initReq && ics_q.initFlag) begin
				ics_d.initFlag = 1'b0;
				exitCnt_d = INIT_EXIT_TICKS - 3'h1;
			end else if (exitCnt_q != 3'h0) begin
				exitCnt_d = exitCnt_q - 3'h1;
			end
		end
		if (loadLive) begin
			liveTime_d = shTime_q;
			liveDate_d = shDate_q;
		end

		// prescaler chain
		asyncTick = rtcTick && running && (asyncCnt_q == 7'h00);
		secondTick = asyncTick && (ss_q == 15'h0000);
		if (!running) begin
			asyncCnt_d = psc_q.async;
			ss_d = psc_q.sync;
		end else if (rtcTick) begin
			asyncCnt_d = asyncTick ? psc_q.async
			                       : asyncCnt_q - 7'h01;
			if (asyncTick) begin
				ss_d = secondTick ? psc_q.sync
				                  : ss_q - 15'h0001;
			end
		end

		// bcd calendar stepping on each second tick
		lastDayNow = lastDay(liveDate_q.month, liveDate_q.year);
		if (secondTick) begin
			liveTime_d.sec = 7'(bcdInc(8'(liveTime_q.sec), SEC_MAX,
				BCD_ZERO));
			if (liveTime_q.sec == 7'(SEC_MAX)) begin
				liveTime_d.min = 7'(bcdInc(8'(liveTime_q.min), SEC_MAX,
					BCD_ZERO));
				if (liveTime_q.min == 7'(SEC_MAX)) begin
					liveTime_d.hour = 6'(bcdInc(8'(liveTime_q.hour),
						HOUR_MAX, BCD_ZERO));
					if (liveTime_q.hour == 6'(HOUR_MAX)) begin
						liveDate_d.weekday = 3'(bcdInc(8'(liveDate_q.weekday),
							WDAY_MAX, BCD_ONE));
						liveDate_d.day = 6'(bcdInc(8'(liveDate_q.day),
							lastDayNow, BCD_ONE));
						if (liveDate_q.day == 6'(lastDayNow)) begin
							liveDate_d.month = 5'(bcdInc(8'(liveDate_q.month),
								MON_MAX, BCD_ONE));
							if (liveDate_q.month == 5'(MON_MAX)) begin
								liveDate_d.year = bcdInc(liveDate_q.year,
									YEAR_MAX, BCD_ZERO);
							end
						end
					end
				end
			end
			// daylight saving step, without carry into the date
			if (ctl_q.addHour) begin
				liveTime_d.hour = 6'(bcdInc(8'(liveTime_d.hour), HOUR_MAX,
					BCD_ZERO));
			end else if (ctl_q.subHour && liveTime_d.hour != 6'h00) begin
				liveTime_d.hour = 6'(bcdDec(8'(liveTime_d.hour)));
			end
			ctl_d.addHour = 1'b0;
			ctl_d.subHour = 1'b0;
		end

		// shadow copy every second rtc tick, not in low power
		shadowCopy = rtcTick && rtcPhase_q && running && !ctl_q.bypass
		             && !lowPowerMode;

		// alarms: arm delay after enable, then edge of full match
		for (int i = 0; i < 2; i++) begin
			if (!ctl_q.alarmEn[i]) begin
				alArm_d[i] = 2'h0;
			end else if (rtcTick && alArm_q[i] != ALARM_ARM_TICKS) begin
				alArm_d[i] = alArm_q[i] + 2'h1;
			end
			alHit[i] = ctl_q.alarmEn[i] && (alArm_q[i] == ALARM_ARM_TICKS)
			           && alarmMatch(alTd_q[i], alSs_q[i], liveTime_q,
			                         liveDate_q, ss_q);
		end
		alPrev_d = alHit;

		// wakeup counter and its clock select
		case (ctl_q.wakeup_clock_select[1:0])
			2'h0:    wuMask = 4'h1;
			2'h1:    wuMask = 4'h3;
			2'h2:    wuMask = 4'h7;
			default: wuMask = 4'hF;
		endcase
		if (rtcTick) begin
			wuDiv_d = wuDiv_q + 4'h1;
		end
		wuTick = ctl_q.wakeup_clock_select[WT_SEC_SEL] ? secondTick
		         : (rtcTick && (wuDiv_q & wuMask) == wuMask);
		wuReload = {ctl_q.wakeup_clock_select[WT_SEC_SEL] & ctl_q.wakeup_clock_select[WT_LONG_SEL],
		            wut_q};
		if (!ctl_q.wakeEn) begin
			wuCnt_d = wuReload;
		end else if (wuTick) begin
			if (wuCnt_q == 17'h0_0000) begin
				wuCnt_d = wuReload;
				wakeSet = 1'b1;
			end else begin
				wuCnt_d = wuCnt_q - 17'h0_0001;
			end
		end

		// apb write, taken at the completing access edge
		setup = psel && !penable;
		wr = psel && penable && pready_q && pwrite && !pslverr_q
		     && backupWriteEnable;
		unlocked = (key_q == KEY_OPEN);
		keyOk = !ics_q.keyPrivOnly || pprot[0];
		bkpOff = paddr - OFF_BKP;
		bkpIdx = 5'(bkpOff >> 2);
		bkpHit = (paddr >= OFF_BKP) && (paddr[1:0] == 2'h0)
		         && (bkpOff < 8'(4 * BKP_NUM));
		if (wr) begin
			case (paddr)
				OFF_TIME: if (unlocked && ics_q.initFlag) begin
					shTime_d = crc_time_t'(pwdata & TIME_MASK);
				end
				OFF_DATE: if (unlocked && ics_q.initFlag) begin
					shDate_d = crc_date_t'(pwdata & DATE_MASK);
				end
				OFF_CTL: ctl_d = crc_ctl_t'(unlocked ? (pwdata & CTL_MASK)
				                 : ((pwdata & CTL_MASK & ~CTL_PROT)
				                    | (ctl_q & CTL_PROT)));
				OFF_ICS: begin
					ics_d.keyPrivOnly = pwdata[8];
					if (unlocked) begin
						ics_d.initReq = pwdata[7];
					end
					ics_d.syncFlag = ics_q.syncFlag & pwdata[5];
					ics_d.wakeFlag = ics_q.wakeFlag & pwdata[2];
					ics_d.alarmFlag = ics_q.alarmFlag & pwdata[1:0];
				end
				OFF_PSC: if (unlocked) begin
					psc_d = crc_psc_t'(pwdata & PSC_MASK);
				end
				OFF_WUT:   wut_d = pwdata[15:0];
				OFF_AL0TD: alTd_d[0] = crc_alrm_t'(pwdata & ALTD_MASK);
				OFF_AL1TD: alTd_d[1] = crc_alrm_t'(pwdata & ALTD_MASK);
				OFF_AL0SS: alSs_d[0] = crc_alss_t'(pwdata & ALSS_MASK);
				OFF_AL1SS: alSs_d[1] = crc_alss_t'(pwdata & ALSS_MASK);
				OFF_WPK: if (keyOk) begin
					case (key_q)
						KEY_LOCKED: key_d = (pwdata[7:0] == KEY_FIRST)
						                    ? KEY_HALF : KEY_LOCKED;
						KEY_HALF:   key_d = (pwdata[7:0] == KEY_SECOND)
						                    ? KEY_OPEN : KEY_LOCKED;
						KEY_OPEN:   key_d = KEY_LOCKED;
						default:    key_d = KEY_LOCKED;
					endcase
				end
				default: if (bkpHit) begin
					bkp_d[bkpIdx] = pwdata;
				end
			endcase
		end

		// hardware sets after software clears, so a set wins
		ics_d.alarmFlag = ics_d.alarmFlag | (alHit & ~alPrev_q);
		if (wakeSet) begin
			ics_d.wakeFlag = 1'b1;
		end
		if (shadowCopy) begin
			shTime_d = liveTime_q;
			shDate_d = liveDate_q;
			shSs_d = ss_q;
			ics_d.syncFlag = 1'b1;
		end
		if (ctl_d.bypass) begin
			ics_d.syncFlag = 1'b0;
		end
		if (sysResetReq) begin
			shTime_d = '0;
			shDate_d = crc_date_t'(DATE_RST);
			shSs_d = '0;
			ics_d.syncFlag = 1'b0;
		end
		if (tamperDetect) begin
			for (int i = 0; i < BKP_NUM; i++) begin
				bkp_d[i] = 32'h0000_0000;
			end
		end

		// apb read mux, captured in the setup cycle
		rdErr = 1'b0;
		case (paddr)
			OFF_TIME:  rdat = ctl_q.bypass ? liveTime_q : shTime_q;
			OFF_DATE:  rdat = ctl_q.bypass ? liveDate_q : shDate_q;
			OFF_SS:    rdat = 32'(ctl_q.bypass ? ss_q : shSs_q);
			OFF_CTL:   rdat = ctl_q;
			OFF_ICS:   rdat = ics_q;
			OFF_PSC:   rdat = psc_q;
			OFF_WUT:   rdat = 32'(wut_q);
			OFF_AL0TD: rdat = alTd_q[0];
			OFF_AL1TD: rdat = alTd_q[1];
			OFF_AL0SS: rdat = alSs_q[0];
			OFF_AL1SS: rdat = alSs_q[1];
			OFF_WPK:   rdat = 32'h0000_0000;
			default: begin
				rdat = bkpHit ? bkp_q[bkpIdx] : 32'h0000_0000;
				rdErr = !bkpHit;
			end
		endcase
		pready_d = setup;
		pslverr_d = setup && rdErr;
		prdata_d = (setup && !pwrite && !rdErr) ? rdat : 32'h0000_0000;
		wakeIrq_d = ics_d.wakeFlag && ctl_d.wakeIrqEn;
	end

	// -------------------------------------------------------------
	// registers, all under the backup-domain reset
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_q <= '0;   rtcPhase_q <= 1'b0;
			asyncCnt_q <= '0; ss_q <= '0; shSs_q <= '0;
			liveTime_q <= '0; shTime_q <= '0;
			liveDate_q <= crc_date_t'(DATE_RST);
			shDate_q <= crc_date_t'(DATE_RST);
			ctl_q <= '0; ics_q <= '0;
			psc_q <= crc_psc_t'(PSC_RST);
			wut_q <= '0; wuCnt_q <= '0; wuDiv_q <= '0;
			for (int i = 0; i < 2; i++) begin
				alTd_q[i] <= '0;
				alSs_q[i] <= '0;
				alArm_q[i] <= '0;
			end
			alPrev_q <= '0; exitCnt_q <= '0; key_q <= KEY_LOCKED;
			for (int i = 0; i < BKP_NUM; i++) begin
				bkp_q[i] <= '0;
			end
			prdata_q <= '0; pready_q <= 1'b0; pslverr_q <= 1'b0;
			wakeIrq_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_d;   rtcPhase_q <= rtcPhase_d;
			asyncCnt_q <= asyncCnt_d; ss_q <= ss_d; shSs_q <= shSs_d;
			liveTime_q <= liveTime_d; shTime_q <= shTime_d;
			liveDate_q <= liveDate_d; shDate_q <= shDate_d;
			ctl_q <= ctl_d; ics_q <= ics_d; psc_q <= psc_d;
			wut_q <= wut_d; wuCnt_q <= wuCnt_d; wuDiv_q <= wuDiv_d;
			alTd_q <= alTd_d; alSs_q <= alSs_d; alArm_q <= alArm_d;
			alPrev_q <= alPrev_d; exitCnt_q <= exitCnt_d; key_q <= key_d;
			bkp_q <= bkp_d;
			prdata_q <= prdata_d; pready_q <= pready_d;
			pslverr_q <= pslverr_d; wakeIrq_q <= wakeIrq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign wakeupIrq = wakeIrq_q;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	keyOpen_a: assert property ($rose(key_q == KEY_OPEN) |->
		$past(key_q) == KEY_HALF) else $error("unlock without first key");
	protPsc_a: assert property (wr && paddr == OFF_PSC && !unlocked
		|=> $stable(psc_q)) else $error("locked prescaler changed");
	shadowSet_a: assert property (shadowCopy && !sysResetReq
		&& !ctl_d.bypass |=> ics_q.syncFlag
		&& shTime_q == $past(liveTime_q))
		else $error("shadow copy lost");
	bypassLow_a: assert property (ctl_q.bypass |=> !ics_q.syncFlag)
		else $error("sync flag set under bypass");
	shadowRst_a: assert property (sysResetReq |=>
		shTime_q == '0 && shDate_q == crc_date_t'(DATE_RST)
		&& shSs_q == '0)
		else $error("shadows not cleared");
	ssReload_a: assert property (secondTick |=>
		ss_q == $past(psc_q.sync)) else $error("subsecond not reloaded");
	wakeExp_a: assert property (wuTick && ctl_q.wakeEn
		&& wuCnt_q == '0 |=> ics_q.wakeFlag && wuCnt_q == $past(wuReload))
		else $error("wakeup expiry missed");
	alarmArm_a: assert property ($rose(ics_q.alarmFlag[0]) |->
		$past(alArm_q[0]) == ALARM_ARM_TICKS) else $error("alarm too early");
	initLoad_a: assert property (loadLive && !secondTick
		|=> liveTime_q == $past(shTime_q)) else $error("init load missed");

	unlock_c: cover property (key_q == KEY_HALF ##1 key_q == KEY_OPEN);
	copy_c:   cover property (shadowCopy);
	wake_c:   cover property ($rose(wakeIrq_q));
	alarm_c:  cover property ($rose(ics_q.alarmFlag[0]));

endmodule : crc_calendar_rtc_core

// ### crc_calendar_rtc_core_tb.sv
module crc_calendar_rtc_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import crc_pkg::*;

	// -----------------------------------------------------
	// stimulus and observed signals
	// -----------------------------------------------------
	logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, lowPowerMode = 1'b0, sysResetReq = 1'b0;
	logic        tamperDetect = 1'b0, backupWriteEnable = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic [2:0]  pprot = 3'h1;
	logic        pready, pslverr, wakeupIrq, se;
	logic [31:0] bk [20];
	logic [6:0]  expSec;
	int          err_total = 0, cmp_count = 0, cyc = 0, n;

	// clock and the core with a short rtc tick
	always #2 clk = ~clk;
	crc_calendar_rtc_core #(.RTC_DIV(8), .BKP_NUM(BKP_WORDS)) i_dut (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lowPowerMode(lowPowerMode), .sysResetReq(sysResetReq),
		.tamperDetect(tamperDetect), .backupWriteEnable(backupWriteEnable),
		.wakeupIrq(wakeupIrq));

	// -----------------------------------------------------
	// tasks
	// -----------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// next bcd second, as a calendar counts
	function automatic logic [6:0] bcdNext(input logic [6:0] s);
		if (s == 7'h59) return 7'h00;
		if (s[3:0] == 4'h9) return {s[6:4] + 3'h1, 4'h0};
		return s + 7'h01;
	endfunction : bcdNext

	// one apb transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : bus

	// poll a register until the masked bits show the wanted value
	task automatic waitv(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v);
		n = 0;
		do begin
			bus(1'b0, a, 32'h0000_0000);
			n++;
		end while ((r & m) !== v && n < 400);
	endtask : waitv

	task automatic close_out();
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	// -----------------------------------------------------
	// main sequence
	// -----------------------------------------------------
	initial begin
		void'($urandom(10));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(1'b0, OFF_DATE, 32'h0000_0000);
		chk(r, DATE_RST);
		bus(1'b1, OFF_PSC, $urandom & PSC_MASK);
		bus(1'b0, OFF_PSC, 32'h0000_0000);
		chk(r, PSC_RST);
		bus(1'b0, 8'h30, 32'h0000_0000);
		chk(se, 1'b1);
		bus(1'b1, OFF_WPK, KEY_FIRST);
		bus(1'b1, OFF_WPK, KEY_SECOND);
		bus(1'b1, OFF_PSC, 32'h0001_0004);
		bus(1'b0, OFF_PSC, 32'h0000_0000);
		chk(r, 32'h0001_0004);
		bus(1'b1, OFF_WPK, 32'h0000_0011);
		bus(1'b1, OFF_PSC, PSC_RST);
		bus(1'b0, OFF_PSC, 32'h0000_0000);
		chk(r, 32'h0001_0004);
		bus(1'b1, OFF_WPK, KEY_FIRST);
		bus(1'b1, OFF_WPK, KEY_SECOND);
		// backup words: random fill, blocked write, tamper wipe
		for (int i = 0; i < 20; i++) begin
			bk[i] = $urandom;
			bus(1'b1, OFF_BKP + 8'(4 * i), bk[i]);
		end
		backupWriteEnable <= 1'b0;
		bus(1'b1, OFF_BKP, ~bk[0]);
		backupWriteEnable <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			bus(1'b0, OFF_BKP + 8'(4 * i), 32'h0000_0000);
			chk(r, bk[i]);
		end
		tamperDetect <= 1'b1;
		@(posedge clk);
		tamperDetect <= 1'b0;
		bus(1'b0, OFF_BKP + 8'h1C, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		// init to one second before a year rollover
		bus(1'b1, OFF_ICS, 32'h0000_0080);
		waitv(OFF_ICS, 32'h0000_0040, 32'h0000_0040);
		chk(r[6], 1'b1);
		bus(1'b1, OFF_TIME, 32'h0023_5959);
		bus(1'b1, OFF_DATE, 32'h0099_B231);
		bus(1'b1, OFF_ICS, 32'h0000_0000);
		bus(1'b1, OFF_CTL, 32'h0000_0020);
		repeat (48) @(posedge clk);
		bus(1'b0, OFF_TIME, 32'h0000_0000);
		chk(r, 32'h0023_5959);
		waitv(OFF_TIME, 32'h0000_007F, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		bus(1'b0, OFF_DATE, 32'h0000_0000);
		chk(r, 32'h0000_C101);
		bus(1'b1, OFF_CTL, 32'h0001_0020);
		waitv(OFF_TIME, 32'h003F_0000, 32'h0001_0000);
		chk(r[21:16], 6'h01);
		// shadow copies, low power and system reset
		bus(1'b1, OFF_CTL, 32'h0000_0000);
		bus(1'b1, OFF_ICS, 32'h0000_0000);
		waitv(OFF_ICS, 32'h0000_0020, 32'h0000_0020);
		chk(r[5], 1'b1);
		lowPowerMode <= 1'b1;
		sysResetReq <= 1'b1;
		@(posedge clk);
		sysResetReq <= 1'b0;
		repeat (32) @(posedge clk);
		bus(1'b0, OFF_TIME, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		bus(1'b0, OFF_ICS, 32'h0000_0000);
		chk(r[5], 1'b0);
		lowPowerMode <= 1'b0;
		waitv(OFF_ICS, 32'h0000_0020, 32'h0000_0020);
		chk(r[5], 1'b1);
		bus(1'b0, OFF_TIME, 32'h0000_0000);
		chk(r[21:16], 6'h01);
		// wakeup timer on rtc/2 with interrupt enabled
		bus(1'b1, OFF_WUT, 32'h0000_0003);
		bus(1'b1, OFF_CTL, 32'h0000_4400);
		n = 0;
		while (wakeupIrq !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk(wakeupIrq, 1'b1);
		bus(1'b0, OFF_ICS, 32'h0000_0000);
		chk(r[2], 1'b1);
		bus(1'b1, OFF_ICS, 32'h0000_0000);
		bus(1'b0, OFF_ICS, 32'h0000_0000);
		chk(r[2], 1'b0);
		// fully masked alarm 0
		bus(1'b1, OFF_CTL, 32'h0000_0000);
		bus(1'b1, OFF_AL0TD, 32'h8080_8080);
		bus(1'b1, OFF_AL0SS, 32'h0100_0000);
		bus(1'b1, OFF_CTL, 32'h0000_0100);
		waitv(OFF_ICS, 32'h0000_0003, 32'h0000_0001);
		chk(r[1:0], 2'h1);
		// alarm 1 on the seconds field only, two seconds ahead
		bus(1'b1, OFF_CTL, 32'h0000_0020);
		bus(1'b0, OFF_TIME, 32'h0000_0000);
		expSec = bcdNext(bcdNext(r[6:0]));
		bus(1'b1, OFF_AL1TD, 32'h8080_8000 | 32'(expSec));
		bus(1'b1, OFF_AL1SS, 32'h0100_0000);
		bus(1'b1, OFF_CTL, 32'h0000_0220);
		waitv(OFF_ICS, 32'h0000_0002, 32'h0000_0002);
		bus(1'b0, OFF_TIME, 32'h0000_0000);
		chk(r[6:0], expSec);
		// key writes gated to privileged accesses
		bus(1'b1, OFF_ICS, 32'h0000_0100);
		pprot <= 3'h0;
		bus(1'b1, OFF_WPK, 32'h0000_0011);
		pprot <= 3'h1;
		bus(1'b1, OFF_PSC, 32'h0002_0005);
		bus(1'b0, OFF_PSC, 32'h0000_0000);
		chk(r, 32'h0002_0005);
		close_out();
	end

endmodule : crc_calendar_rtc_core_tb
